/* design/icb_ctrl.sv */
// Purpose: multi-master two-wire bus controller with an APB register file
// Assumes: pclk 250 MHz; APB slave answers with no wait states
// Notes:   byte engine follows the sampled bus, so master and slave share one shifter
// Overview of operation
// RULE1: one irq for arb-lost, byte-done, address match
// RULE2: irq reaches cpu only with enable bit set
// RULE3: software clears irq flag by writing zero
// RULE4: software sets divider, address, enable, then mode
// RULE5: status busy 0x20, irq 0x02, noack 0x01
// RULE6: master plus transmit on free bus starts
// RULE7: start waits out the minimum bus-free time
// RULE8: each byte sets done and irq flags; a byte after arbitration loss without address match sets only irq
// RULE9: data access in current direction clears done
// RULE10: master stays transmit at address-cycle interrupt
// RULE11: slave direction status valid only with match
// RULE12: clearing master bit issues a stop
// RULE13: master receiver noacks then stops before reading
// RULE14: repeated-start bit restarts without a stop
// RULE15: match flag set on own address, ctrl write clears
// RULE16: later data bytes show match flag clear
// RULE17: slave holds scl low until data access
// RULE18: slave transmitter checks ack, dummy-reads on noack
// RULE19: arbitration loss: slave receive, finish byte, interrupt
// RULE20: start on busy bus fails with arb-lost
// RULE21: software tests and clears arb-lost first
// RULE22: polling software watches irq flag, not done
// RULE23: loser in address cycle still answers as slave
// RULE24: irq stays high until flag cleared
`timescale 1ns/1ns
module icb_ctrl (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt request
  output logic             irq,
  // two-wire link
  icb_link_if.dev          link
);
  import icb_pkg::*;

  logic [7:0]  own_slave_addr_reg, scl_divider_reg, bus_control_reg, serial_data_reg;
  logic [7:0]  rd_byte_reg, tx_shift_reg, rx_shift_reg;
  logic        pslverr_reg, rs_req_reg, hold_reg, lost_reg, early_reg;
  logic        xfer_done_flag, own_addr_match_flag, bus_busy_flag, arb_lost_flag;
  logic        slave_dir_status, irq_flag, rx_noack_flag;
  logic [3:0]  bit_cnt_reg;
  logic        ack_slot_reg, addr_phase_reg, addressed_reg;
  logic [15:0] tmr_reg;
  logic [10:0] free_cnt_reg;
  icb_mst_t    st_reg, st_next;
  logic        scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;

  icb_pin_sync u_sync (
    .clk       (pclk),
    .rst_n     (presetn),
    .scl_pin   (link.scl_line),
    .sda_pin   (link.sda_line),
    .scl_s     (scl_s),
    .sda_s     (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // apb decode; unmapped offsets answer with pslverr
  wire sel_addr = (paddr == OFS_ADDR);
  wire sel_div  = (paddr == OFS_DIV);
  wire sel_ctrl = (paddr == OFS_CTRL);
  wire sel_stat = (paddr == OFS_STAT);
  wire sel_data = (paddr == OFS_DATA);
  wire mapped   = sel_addr | sel_div | sel_ctrl | sel_stat | sel_data;
  wire setup    = psel & !penable;
  wire wr       = psel & penable & pwrite & mapped;
  wire rd       = psel & penable & !pwrite & mapped;
  wire wr_ctrl  = wr & sel_ctrl;
  wire wr_stat  = wr & sel_stat;
  wire wr_data  = wr & sel_data;
  wire rd_data  = rd & sel_data;

  // control fields
  wire en       = bus_control_reg[CTL_EN];
  wire ms       = bus_control_reg[CTL_MS];
  wire tx       = bus_control_reg[CTL_TX];
  wire noack    = bus_control_reg[CTL_NOACK];

  // status word; direction shows only while the match flag stands
  wire [7:0] stat_word = {xfer_done_flag, own_addr_match_flag, bus_busy_flag, arb_lost_flag, 1'b0,
                          slave_dir_status & own_addr_match_flag, irq_flag, rx_noack_flag}; // see RULE5 RULE11
  wire [7:0] rd_mux = sel_addr ? own_slave_addr_reg :
                      sel_div  ? scl_divider_reg :
                      sel_ctrl ? bus_control_reg :
                      sel_stat ? stat_word :
                      sel_data ? serial_data_reg : 8'h00;

  // byte engine events
  wire part       = ms | addressed_reg | lost_reg;
  wire byte_end   = scl_fall & (bit_cnt_reg == LAST_BIT);
  wire mst_run    = (st_reg == M_LOW) | (st_reg == M_HIGH);                     // no sda drive while waiting to start
  wire sending    = (ms & mst_run & (addr_phase_reg | tx)) | (addressed_reg & !addr_phase_reg & tx);
  wire arb_loss   = scl_rise & ms & sending & !ack_slot_reg & tx_shift_reg[7] & !sda_s;
  wire match_now  = scl_rise & addr_phase_reg & !ms & (bit_cnt_reg == 4'h7) &
                    (rx_shift_reg[6:0] == own_slave_addr_reg[7:1]);              // see RULE23
  wire ms_set_req = wr_ctrl & pwdata[CTL_MS] & !ms & en;
  wire start_busy = (ms_set_req & bus_busy_flag) | ((st_reg == M_FREE) & bus_busy_flag); // see RULE20
  wire release_io = (tx & wr_data) | (!tx & rd_data);                          // see RULE9 RULE17
  wire ev_byte    = byte_end & part;
  wire eng_owns   = (st_reg == M_RS1) | (st_reg == M_RS2) | (st_reg == M_START) |
                    (st_reg == M_STOP1) | (st_reg == M_STOP2);
  wire stretchy   = (st_reg == M_HIGH) | (st_reg == M_RS2) | (st_reg == M_STOP2);
  wire tmr_done   = (tmr_reg == 16'h0000);

  // apb answer: data and error latched in setup, no wait states
  assign pready  = 1'b1;
  assign pslverr = pslverr_reg;
  assign prdata  = {24'h00_0000, rd_byte_reg};
  assign irq     = irq_flag & bus_control_reg[CTL_IE];                         // see RULE1 RULE2 RULE24

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_byte_reg <= 8'h00;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      rd_byte_reg <= rd_mux;
      pslverr_reg <= !mapped;
    end
  end

  // software registers; arbitration loss overrides a same-cycle write of the mode bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_slave_addr_reg <= ADDR_RST;
      scl_divider_reg    <= DIV_RST;
      bus_control_reg    <= CTRL_RST;
      serial_data_reg    <= DATA_RST;
      rs_req_reg         <= 1'b0;
    end else begin
      if (wr & sel_addr) own_slave_addr_reg <= pwdata[7:0];
      if (wr & sel_div) scl_divider_reg <= pwdata[7:0];
      if (wr_ctrl) bus_control_reg <= pwdata[7:0] & CTRL_WMASK;
      if (arb_loss | start_busy) begin
        bus_control_reg[CTL_MS] <= 1'b0;                                       // see RULE19 RULE20
        bus_control_reg[CTL_TX] <= 1'b0;
      end
      if (wr_data) serial_data_reg <= pwdata[7:0];
      else if (ev_byte) serial_data_reg <= rx_shift_reg;
      if (wr_ctrl & pwdata[CTL_RSTA] & ms) rs_req_reg <= 1'b1;                 // see RULE14
      else if ((st_reg == M_RS1) | !ms) rs_req_reg <= 1'b0;
    end
  end

  // flags: a hardware set wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_done_flag      <= 1'b0;
      own_addr_match_flag <= 1'b0;
      bus_busy_flag       <= 1'b0;
      arb_lost_flag       <= 1'b0;
      slave_dir_status    <= 1'b0;
      irq_flag            <= 1'b0;
      rx_noack_flag       <= 1'b0;
    end else begin
      if (ev_byte & (!lost_reg | addressed_reg)) xfer_done_flag <= 1'b1;       // see RULE8
      else if (release_io) xfer_done_flag <= 1'b0;                             // see RULE9
      if (ev_byte & addr_phase_reg & addressed_reg) own_addr_match_flag <= 1'b1; // see RULE15
      else if (wr_ctrl | ev_byte | stop_det) own_addr_match_flag <= 1'b0;      // see RULE15 RULE16
      if (start_det) bus_busy_flag <= 1'b1;
      else if (stop_det) bus_busy_flag <= 1'b0;
      if (start_busy | (byte_end & lost_reg)) arb_lost_flag <= 1'b1;           // see RULE19 RULE20
      else if (wr_stat & !pwdata[ST_AL]) arb_lost_flag <= 1'b0;                // see RULE21
      if (ev_byte | start_busy) irq_flag <= 1'b1;                              // see RULE1 RULE8
      else if (wr_stat & !pwdata[ST_IRQ]) irq_flag <= 1'b0;                    // see RULE3 RULE24
      if (match_now) slave_dir_status <= sda_s;                                // see RULE11
      if (scl_rise & (bit_cnt_reg == ACK_BIT) & part) rx_noack_flag <= sda_s;
    end
  end

  // byte engine, clocked by the sampled bus so it serves master and slave alike
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_reg    <= 4'h0;
      ack_slot_reg   <= 1'b0;
      addr_phase_reg <= 1'b0;
      addressed_reg  <= 1'b0;
      rx_shift_reg   <= 8'h00;
      tx_shift_reg   <= 8'hFF;
    end else begin
      if (start_det) begin
        bit_cnt_reg    <= 4'h0;
        ack_slot_reg   <= 1'b0;
        addr_phase_reg <= 1'b1;
        addressed_reg  <= 1'b0;
      end else if (scl_rise & (bit_cnt_reg != LAST_BIT)) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (bit_cnt_reg < ACK_BIT) rx_shift_reg <= {rx_shift_reg[6:0], sda_s};
        if (match_now) addressed_reg <= 1'b1;                                  // see RULE15
      end else if (byte_end) begin
        bit_cnt_reg    <= 4'h0;
        ack_slot_reg   <= 1'b0;
        addr_phase_reg <= 1'b0;
      end else if (scl_fall) begin
        if (bit_cnt_reg == ACK_BIT) ack_slot_reg <= 1'b1;
        else if (bit_cnt_reg != 4'h0) tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
      end
      if (stop_det | !en) addressed_reg <= 1'b0;
      if (wr_data) tx_shift_reg <= pwdata[7:0];                                // see RULE6 RULE14
    end
  end

  // hold scl low between bytes; a lost master never holds unless addressed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= 1'b0;
      lost_reg <= 1'b0;
      early_reg <= 1'b0;
    end else begin
      if (wr_data & (eng_owns | (st_reg == M_FREE))) early_reg <= 1'b1;        // see RULE7
      else if ((st_reg == M_LOW) | (st_reg == M_IDLE)) early_reg <= 1'b0;
      if (((st_reg == M_START) & tmr_done & !early_reg & !wr_data) |
          (byte_end & (ms | addressed_reg))) hold_reg <= 1'b1;                 // see RULE6 RULE17
      else if (release_io | (st_reg == M_RS1) | (st_reg == M_STOP1) | stop_det | !en) hold_reg <= 1'b0;
      if (arb_loss) lost_reg <= 1'b1;                                          // see RULE19
      else if (st_reg == M_IDLE) lost_reg <= 1'b0;
    end
  end

  // bus-free time since the last stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) free_cnt_reg <= 11'h000;
    else if (bus_busy_flag) free_cnt_reg <= 11'h000;
    else if (free_cnt_reg != BUF_CYC) free_cnt_reg <= free_cnt_reg + 11'h001;
  end

  // master sequencer: start, bit clocking, repeated start, stop
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      M_IDLE:  if (ms_set_req & !bus_busy_flag) st_next = M_FREE;              // see RULE6
      M_FREE: begin
        if (bus_busy_flag) st_next = M_IDLE;
        else if (free_cnt_reg == BUF_CYC) st_next = M_START;                   // see RULE7
      end
      M_START: if (tmr_done) st_next = M_LOW;
      M_LOW: begin
        if (bit_cnt_reg != 4'h0) begin
          if (tmr_done) st_next = M_HIGH;
        end else if (lost_reg) st_next = M_IDLE;                               // see RULE19
        else if (!ms) st_next = M_STOP1;                                       // see RULE12 RULE13
        else if (rs_req_reg) st_next = M_RS1;                                  // see RULE14
        else if (!hold_reg & tmr_done) st_next = M_HIGH;                       // see RULE10
      end
      M_HIGH:  if (scl_s & tmr_done) st_next = M_LOW;
      M_RS1:   if (tmr_done) st_next = M_RS2;
      M_RS2:   if (scl_s & tmr_done) st_next = M_START;
      M_STOP1: if (tmr_done) st_next = M_STOP2;
      M_STOP2: if (scl_s & tmr_done) st_next = M_IDLE;
      default: st_next = M_IDLE;
    endcase
    if (!en) st_next = M_IDLE;
  end

  // high phases count only while the line is really high, so stretching slows us
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg  <= M_IDLE;
      tmr_reg <= 16'h0000;
    end else begin
      st_reg <= st_next;
      if (st_next != st_reg) tmr_reg <= icb_half_len(scl_divider_reg);
      else if (!tmr_done & (scl_s | !stretchy)) tmr_reg <= tmr_reg - 16'h0001;
    end
  end

  // line drive; sda is held low after start until scl is seen low, avoiding a false stop
  wire eng_scl_low = (st_reg == M_LOW) | (st_reg == M_RS1) | (st_reg == M_STOP1);
  wire eng_sda_low = (st_reg == M_START) | (st_reg == M_STOP1) | (st_reg == M_STOP2) |
                     ((st_reg == M_LOW) & scl_s & (bit_cnt_reg == 4'h0));
  wire drive_data  = sending & !ack_slot_reg & !tx_shift_reg[7];
  wire drive_ack   = ack_slot_reg & ((addr_phase_reg & addressed_reg) |
                     (!addr_phase_reg & !tx & (ms | addressed_reg) & !noack)); // see RULE13
  assign link.dev_scl_o  = 1'b0;
  assign link.dev_sda_o  = 1'b0;
  assign link.dev_scl_oe = en & (eng_scl_low | hold_reg);                      // see RULE17
  assign link.dev_sda_oe = en & (eng_sda_low | (!eng_owns & (drive_data | drive_ack)));
endmodule : icb_ctrl

/* design/icb_link_if.sv */
// Purpose: open-drain two-wire link between the controller and its bus peer
// Assumes: external pull-ups, so an undriven line reads high
// Notes:   each end gives output value and output enable; the wire-and is resolved here
`timescale 1ns/1ns
interface icb_link_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic peer_scl_o;
  logic peer_scl_oe;
  logic peer_sda_o;
  logic peer_sda_oe;
  logic scl_line;
  logic sda_line;

  // wired-and with pull-up
  assign scl_line = !((dev_scl_oe & !dev_scl_o) | (peer_scl_oe & !peer_scl_o));
  assign sda_line = !((dev_sda_oe & !dev_sda_o) | (peer_sda_oe & !peer_sda_o));

  modport dev  (output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe, input scl_line, sda_line);
  modport peer (output peer_scl_o, peer_scl_oe, peer_sda_o, peer_sda_oe, input scl_line, sda_line);
endinterface : icb_link_if

/* design/icb_peer.sv */
// Purpose: simple bus target on the far end of the link, at a fixed 7-bit address
// Assumes: never stretches scl; acks every written byte while addressed
// Notes:   on a read it sends tx_byte, reloading it after each master ack
`timescale 1ns/1ns
module icb_peer (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // user side
  input  wire logic [6:0] peer_addr,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte,
  output logic            rx_strobe,
  output logic            tx_taken,
  // two-wire link
  icb_link_if.peer        link
);
  import icb_pkg::*;

  logic       scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  logic [3:0] bit_cnt_reg;
  logic       ack_slot_reg, addr_phase_reg, addressed_reg, match_reg, dir_reg, nacked_reg;
  logic [7:0] rx_shift_reg, tx_shift_reg;

  icb_pin_sync u_sync (
    .clk       (pclk),
    .rst_n     (presetn),
    .scl_pin   (link.scl_line),
    .sda_pin   (link.sda_line),
    .scl_s     (scl_s),
    .sda_s     (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  wire byte_end  = scl_fall & (bit_cnt_reg == LAST_BIT);
  wire reading   = addressed_reg & dir_reg & !addr_phase_reg;

  // bit counting, address decode and byte moves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_reg    <= 4'h0;
      ack_slot_reg   <= 1'b0;
      addr_phase_reg <= 1'b0;
      addressed_reg  <= 1'b0;
      match_reg      <= 1'b0;
      dir_reg        <= 1'b0;
      nacked_reg     <= 1'b0;
      rx_shift_reg   <= 8'h00;
      tx_shift_reg   <= 8'hFF;
      rx_byte        <= 8'h00;
      rx_strobe      <= 1'b0;
      tx_taken       <= 1'b0;
    end else begin
      rx_strobe <= 1'b0;
      tx_taken  <= 1'b0;
      if (start_det | stop_det) begin
        bit_cnt_reg    <= 4'h0;
        ack_slot_reg   <= 1'b0;
        addr_phase_reg <= start_det;
        addressed_reg  <= 1'b0;
        match_reg      <= 1'b0;
        nacked_reg     <= 1'b0;
      end else if (scl_rise & (bit_cnt_reg != LAST_BIT)) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (bit_cnt_reg < ACK_BIT) rx_shift_reg <= {rx_shift_reg[6:0], sda_s};
        if (addr_phase_reg & (bit_cnt_reg == 4'h7)) match_reg <= (rx_shift_reg[6:0] == peer_addr);
        if (reading & (bit_cnt_reg == ACK_BIT)) nacked_reg <= sda_s;           // see RULE13
      end else if (byte_end) begin
        bit_cnt_reg    <= 4'h0;
        ack_slot_reg   <= 1'b0;
        addr_phase_reg <= 1'b0;
        if (addr_phase_reg) begin
          addressed_reg <= match_reg;
          dir_reg       <= rx_shift_reg[0];                                    // see RULE6 RULE10
        end
        if ((addr_phase_reg & match_reg & rx_shift_reg[0]) | (reading & !nacked_reg)) begin
          tx_shift_reg <= tx_byte;
          tx_taken     <= 1'b1;
        end
        if (addressed_reg & !dir_reg & !addr_phase_reg) begin
          rx_byte   <= rx_shift_reg;
          rx_strobe <= 1'b1;
        end
      end else if (scl_fall) begin
        if (bit_cnt_reg == ACK_BIT) ack_slot_reg <= 1'b1;
        else if (bit_cnt_reg != 4'h0) tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
      end
    end
  end

  // ack own address and written bytes; after a master noack sda stays released
  wire drive_ack  = ack_slot_reg & ((addr_phase_reg & match_reg) |
                    (addressed_reg & !dir_reg & !addr_phase_reg));
  wire drive_data = reading & !nacked_reg & !ack_slot_reg & !tx_shift_reg[7]; // see RULE18
  assign link.peer_scl_o  = 1'b0;
  assign link.peer_scl_oe = 1'b0;
  assign link.peer_sda_o  = 1'b0;
  assign link.peer_sda_oe = drive_ack | drive_data;
endmodule : icb_peer

/* design/icb_pin_sync.sv */
// Purpose: bring scl and sda into the pclk domain and find edges and bus conditions
// Assumes: lines idle high; two flip-flops per line before any logic
// Notes:   all outputs lag the wire by two clocks
`timescale 1ns/1ns
module icb_pin_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // raw lines
  input  wire logic scl_pin,
  input  wire logic sda_pin,
  // sampled levels and events
  output logic      scl_s,
  output logic      sda_s,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det
);
  logic [1:0] scl_ff;
  logic [1:0] sda_ff;
  logic       scl_d;
  logic       sda_d;

  // synchroniser plus one delay stage for edge finding
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_ff <= 2'b11;
      sda_ff <= 2'b11;
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_ff <= {scl_ff[0], scl_pin};
      sda_ff <= {sda_ff[0], sda_pin};
      scl_d  <= scl_ff[1];
      sda_d  <= sda_ff[1];
    end
  end

  // sda moving while scl stays high marks start or stop
  assign scl_s     = scl_ff[1];
  assign sda_s     = sda_ff[1];
  assign scl_rise  = scl_ff[1] & !scl_d;
  assign scl_fall  = !scl_ff[1] & scl_d;
  assign start_det = scl_ff[1] & scl_d & sda_d & !sda_ff[1];
  assign stop_det  = scl_ff[1] & scl_d & !sda_d & sda_ff[1];
endmodule : icb_pin_sync

/* design/icb_pkg.sv */
// Purpose: shared constants and types for the two-wire bus controller and its bus peer
// Assumes: pclk at 250 MHz; all registers are one aligned 32-bit word, data in bits 7:0
// Notes:   bit positions are indices into the low byte of a register word
package icb_pkg;

  // clock and bus-free timing
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          T_BUF_NS      = 4700;
  localparam logic [10:0] BUF_CYC       = 11'((T_BUF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // register byte offsets
  localparam logic [7:0] OFS_ADDR = 8'h00;
  localparam logic [7:0] OFS_DIV  = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_DATA = 8'h10;

  // bus_control_reg bit positions
  localparam int CTL_EN    = 7;
  localparam int CTL_IE    = 6;
  localparam int CTL_MS    = 5;
  localparam int CTL_TX    = 4;
  localparam int CTL_NOACK = 3;
  localparam int CTL_RSTA  = 2;
  localparam logic [7:0] CTRL_WMASK = 8'hF8;

  // bus_status_reg bit positions
  localparam int ST_DONE  = 7;
  localparam int ST_MATCH = 6;
  localparam int ST_BUSY  = 5;
  localparam int ST_AL    = 4;
  localparam int ST_SRW   = 2;
  localparam int ST_IRQ   = 1;
  localparam int ST_NACK  = 0;

  // values after reset
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] DIV_RST  = 8'h1F;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // bit slots within a byte: eight data, then the acknowledge
  localparam logic [3:0] ACK_BIT  = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h9;

  // master sequencer states
  typedef enum logic [3:0] {
    M_IDLE, M_FREE, M_START, M_LOW, M_HIGH, M_RS1, M_RS2, M_STOP1, M_STOP2
  } icb_mst_t;

  // scl half period: eight clocks per divider step
  function automatic logic [15:0] icb_half_len(input logic [7:0] div);
    icb_half_len = {4'h0, ({1'b0, div} + 9'h001), 3'b000};
  endfunction : icb_half_len

endpackage : icb_pkg

/* sim/icb_link_monitor.sv */
// Purpose: wire-level checks on the link between controller and peer
// Assumes: raw wired-and lines with pull-ups
// Notes:   helper logic tracks bus busy, owner and bus-free time
`timescale 1ns/1ns
module icb_link_monitor
  import icb_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link signals
  input wire logic dev_scl_o,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic peer_scl_oe,
  input wire logic peer_sda_oe,
  input wire logic scl_line,
  input wire logic sda_line
);
  logic [11:0] gap_reg;
  logic        busy_reg;
  logic        own_reg;
  logic        hi_q;
  logic        sda_q;
  // start and stop seen on the raw lines
  wire         st = scl_line && hi_q && sda_q && !sda_line;
  wire         sp = scl_line && hi_q && !sda_q && sda_line;
  // reset counts as a long idle, so the free-time count starts saturated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {hi_q, sda_q, busy_reg, own_reg} <= 4'b1100;
      gap_reg <= 12'hFFF;
    end else begin
      {hi_q, sda_q} <= {scl_line, sda_line};
      busy_reg <= st | (busy_reg & !sp);
      own_reg <= (st & dev_sda_oe) | (own_reg & !sp & !st);
      gap_reg <= sp ? 12'h000 : gap_reg + {11'h000, gap_reg != 12'hFFF};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pins_open_drain: assert property (!dev_scl_o && !dev_sda_o)
    else $error("device drives a line high");
  a_peer_no_stretch: assert property (!peer_scl_oe)
    else $error("peer pulled scl");
  a_start_after_free: assert property (st && dev_sda_oe && !own_reg |-> gap_reg >= 12'(BUF_CYC))
    else $error("start too soon after stop");
  a_start_not_busy: assert property (st && dev_sda_oe |-> !busy_reg || own_reg)
    else $error("start on a busy bus");
  a_stop_by_owner: assert property (sp |-> own_reg && $past(dev_sda_oe))
    else $error("stop without owning the bus");
  a_start_scl_hold: assert property (st |=> scl_line [*6])
    else $error("scl fell too soon after start");
  a_scl_high_min: assert property ($rose(scl_line) |=> scl_line [*5])
    else $error("scl high phase too short");
  a_peer_sda_low: assert property ($changed(peer_sda_oe) |-> !scl_line)
    else $error("peer moved sda while scl high");
  cover property (st && own_reg);
  cover property (st && !own_reg);
  cover property (sp);
endmodule : icb_link_monitor

/* sim/test_i2c_controller_status_and_sequencing.sv */
// Purpose: bench for controller and peer on one link
// Assumes: divider 0 gives 8-clock scl halves
// Notes:   no third master, so address match goes unexercised and busy-start is left to the checker
`timescale 1ns/1ns
module test_i2c_controller_status_and_sequencing;
  import icb_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] v; logic e;} icb_row_t;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0]  paddr = 8'h00, rx_byte;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, irq, rx_strobe;
  int          n_errors = 0, n_checks = 0, cyc = 0, n_rx = 0;
  // reset values, last row is an unmapped offset
  icb_row_t    rows [6] = '{'{OFS_ADDR, ADDR_RST, 0}, '{OFS_DIV, DIV_RST, 0}, '{OFS_CTRL, CTRL_RST, 0},
                            '{OFS_STAT, 8'h00, 0}, '{OFS_DATA, DATA_RST, 0}, '{8'h14, 8'h00, 1}};
  icb_link_if lk ();
  icb_ctrl icb_ctrl_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .link(lk));
  icb_peer icb_peer_inst (.pclk(pclk), .presetn(presetn), .peer_addr(7'h2A), .tx_byte(8'h3C),
    .rx_byte(rx_byte), .rx_strobe(rx_strobe), .tx_taken(), .link(lk));
  icb_link_monitor icb_link_monitor_inst (.pclk(pclk), .presetn(presetn), .dev_scl_o(lk.dev_scl_o),
    .dev_sda_o(lk.dev_sda_o), .dev_sda_oe(lk.dev_sda_oe), .peer_scl_oe(lk.peer_scl_oe),
    .peer_sda_oe(lk.peer_sda_oe), .scl_line(lk.scl_line), .sda_line(lk.sda_line));
  always #2 pclk = ~pclk;
  // written bytes seen by the peer
  always @(posedge pclk) if (rx_strobe) n_rx++;
  // a hang ends the run as a failure
  always @(posedge pclk) if (++cyc == 20000) begin
    n_errors++;
    end_sim();
  end
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", s, x, g);
    end
  endtask : chk
  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h00_0000, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    chk("irq", 0, irq);
    foreach (rows[i]) begin
      apb(rows[i].a, 0, 8'h00);
      chk("reg", rows[i].v, rd);
      chk("slverr", rows[i].e, er);
    end
    // divider, own address, enable, then master transmit with irq on
    apb(OFS_DIV, 1, 8'h00);
    apb(OFS_ADDR, 1, 8'h10);
    apb(OFS_CTRL, 1, 8'h80);
    apb(OFS_CTRL, 1, 8'hF0);
    apb(OFS_DATA, 1, 8'h54);
    wait (irq === 1'b1);
    apb(OFS_STAT, 0, 8'h00);
    chk("addr stat", 8'hA2, rd);
    apb(OFS_CTRL, 0, 8'h00);
    chk("ctrl tx", 8'hF0, rd);
    apb(OFS_STAT, 1, 8'h00);
    apb(OFS_DATA, 1, 8'hA5);
    chk("irq", 0, irq);
    apb(OFS_STAT, 0, 8'h00);
    chk("tx stat", 8'h20, rd);
    wait (irq === 1'b1);
    @(posedge pclk);
    chk("peer rx", 8'hA5, rx_byte);
    // repeated start for a one-byte read
    apb(OFS_STAT, 1, 8'h00);
    apb(OFS_CTRL, 1, 8'hF4);
    apb(OFS_DATA, 1, 8'h55);
    wait (irq === 1'b1);
    apb(OFS_STAT, 0, 8'h00);
    chk("rs stat", 8'hA2, rd);
    apb(OFS_STAT, 1, 8'h00);
    apb(OFS_CTRL, 1, 8'hE8);
    apb(OFS_DATA, 0, 8'h00);
    wait (irq === 1'b1);
    apb(OFS_CTRL, 1, 8'hC8);
    apb(OFS_DATA, 0, 8'h00);
    chk("rx byte", 8'h3C, rd);
    do apb(OFS_STAT, 0, 8'h00); while (rd[ST_BUSY] !== 1'b0);
    chk("idle stat", 8'h02, rd & 32'h0000_00FE);
    // absent target with irq off: poll the flag, expect a noack
    apb(OFS_STAT, 1, 8'h00);
    apb(OFS_CTRL, 1, 8'hB0);
    apb(OFS_DATA, 1, 8'h22);
    do apb(OFS_STAT, 0, 8'h00); while (rd[ST_IRQ] !== 1'b1);
    chk("irq", 0, irq);
    chk("nack stat", 8'hA3, rd);
    apb(OFS_CTRL, 1, 8'h80);
    chk("peer strobes", 1, n_rx);
    end_sim();
  end
endmodule : test_i2c_controller_status_and_sequencing
